// >>> inc/iolc_pkg.sv
// Constants for the I/O line configuration, blink and PWM block
package iolc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BLINK_STEP_MS = 10;
  localparam int unsigned PWM_STEP_MS   = 100;
  localparam int unsigned BLINK_STEP_CYC =
    (BLINK_STEP_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned PWM_PER_BLINK = PWM_STEP_MS / BLINK_STEP_MS;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_SLP_FN  = 8'h00;
  localparam logic [7:0] OFS_LT      = 8'h04;
  localparam logic [7:0] OFS_PR      = 8'h08;
  localparam logic [7:0] OFS_PD      = 8'h0C;
  localparam logic [7:0] OFS_RP      = 8'h10;
  localparam logic [7:0] OFS_VIN     = 8'h14;
  localparam logic [7:0] OFS_THR     = 8'h18;
  localparam logic [7:0] OFS_FW      = 8'h1C;
  localparam logic [7:0] OFS_HW      = 8'h20;
  localparam logic [7:0] OFS_LED_FN  = 8'h24;
  localparam logic [7:0] OFS_ISTS    = 8'h28;
  localparam logic [7:0] OFS_IMSK    = 8'h2C;
  localparam logic [7:0] OFS_LINE    = 8'h30;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  SLP_FN_RST = 8'h01;
  localparam logic [7:0]  LED_FN_RST = 8'h01;
  localparam logic [7:0]  LT_RST     = 8'h00;
  localparam logic [14:0] PR_RST     = 15'h1FFF;
  localparam logic [14:0] PD_RST     = 15'h1FBF;
  localparam logic [7:0]  RP_RST     = 8'h28;
  localparam logic [15:0] THR_RST    = 16'h0000;

  // ----------------------------------------------------------------
  // Line function codes and special values
  // ----------------------------------------------------------------
  localparam logic [7:0] FN_OFF  = 8'h00;
  localparam logic [7:0] FN_ALT  = 8'h01;
  localparam logic [7:0] FN_DIN  = 8'h03;
  localparam logic [7:0] FN_LOW  = 8'h04;
  localparam logic [7:0] FN_HIGH = 8'h05;
  localparam logic [7:0] RP_ALWAYS = 8'hFF;
  localparam logic [7:0] BLINK_DEF = 8'h19;
  localparam int unsigned MASK_VIN_BIT = 7;

  // ----------------------------------------------------------------
  // Interrupt bits and bus responses
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_W       = 3;
  localparam int unsigned IRQ_PKT     = 0;
  localparam int unsigned IRQ_PWM_END = 1;
  localparam int unsigned IRQ_LOW_VIN = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : iolc_pkg

// >>> logic/iolc_top.sv
// I/O line configuration, join LED blink, signal-strength PWM and supply
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps

module iolc_top #(
  parameter int unsigned TICK_CYC   = iolc_pkg::BLINK_STEP_CYC,
  parameter int unsigned PWM_DIV    = iolc_pkg::PWM_PER_BLINK,
  parameter logic [15:0] FW_VERSION = 16'h1000,  // Arbitrary value
  parameter logic [15:0] HW_VERSION = 16'h5A01   // Arbitrary value
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic [iolc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [iolc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        joined_i,
  input  wire logic                        sleep_state_i,
  input  wire logic                        gpio_line_nine_i,
  output logic                             gpio_line_nine_o,
  output logic                             gpio_line_nine_oe_o,
  output logic                             gpio_line_five_o,
  output logic                             gpio_line_five_oe_o,
  input  wire logic                        pkt_rx_i,
  input  wire logic [7:0]                  received_signal_strength_i,
  output logic                             strength_pwm_o,
  output logic [14:0]                      pull_en_o,
  output logic [14:0]                      pull_up_o,
  output logic [14:0]                      pull_dn_o,
  input  wire logic [15:0]                 supply_mv_i,
  input  wire logic                        smp_req_i,
  input  wire logic [7:0]                  adc_mask_i,
  output logic                             smp_valid_o,
  output logic                             smp_supply_o,
  output logic [7:0]                       adc_mask_o,
  output logic                             irq_o
);
  import iolc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]       join_s;
    logic [1:0]       slp_s;
    logic [1:0]       din_s;
    logic [31:0]      div;
    logic [3:0]       sub;
    logic             t10;
    logic             t100;
    logic [7:0]       slp_fn;
    logic [7:0]       led_fn;
    logic [7:0]       lt;
    logic [7:0]       rp;
    logic [14:0]      pr;
    logic [14:0]      pd;
    logic [15:0]      thr;
    logic [IRQ_W-1:0] ists;
    logic [IRQ_W-1:0] imsk;
    logic [7:0]       bcnt;
    logic             led;
    logic [7:0]       duty;
    logic [7:0]       pcnt;
    logic [7:0]       ptmr;
    logic             pact;
    logic             pwm;
    logic             g9;
    logic             g9oe;
    logic             g5;
    logic             g5oe;
    logic [14:0]      pu;
    logic [14:0]      pdn;
    logic             app;
    logic             smp;
    logic [7:0]       amask;
    logic             irq;
    logic             awg;
    logic             wg;
    logic [7:0]       awa;
    logic [31:0]      wd;
    logic [3:0]       ws;
    logic             awr;
    logic             wr;
    logic             bv;
    logic [1:0]       br;
    logic             arr;
    logic             rv;
    logic [31:0]      rd;
    logic [1:0]       rr;
  } iolc_state_s;

  localparam iolc_state_s ST_RST = '{
    slp_fn: SLP_FN_RST, led_fn: LED_FN_RST, lt: LT_RST, rp: RP_RST,
    pr: PR_RST, pd: PD_RST, thr: THR_RST,
    pu: PR_RST & PD_RST, pdn: PR_RST & ~PD_RST,
    awr: 1'b1, wr: 1'b1, arr: 1'b1, default: '0};

  iolc_state_s q;
  iolc_state_s n;
  logic        wr_do;
  logic        rd_do;

  assign wr_do = q.awg && q.wg && !q.bv;
  assign rd_do = s_axi_arvalid && q.arr;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] iolc_merge(input logic [31:0] o,
                                             input logic [31:0] d,
                                             input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : iolc_merge

  // Bit 32 flags a mapped address
  function automatic logic [32:0] iolc_rdval(input iolc_state_s s,
                                             input logic [7:0]  a,
                                             input logic [15:0] vin);
    logic [32:0] r;
    r = {1'b1, 32'h0};
    unique case ({a[7:2], 2'b00})
      OFS_SLP_FN: r[7:0]  = s.slp_fn;
      OFS_LT:     r[7:0]  = s.lt;
      OFS_PR:     r[14:0] = s.pr;
      OFS_PD:     r[14:0] = s.pd;
      OFS_RP:     r[7:0]  = s.rp;
      OFS_VIN:    r[15:0] = vin;
      OFS_THR:    r[15:0] = s.thr;
      OFS_FW:     r[15:0] = FW_VERSION;
      OFS_HW:     r[15:0] = HW_VERSION;
      OFS_LED_FN: r[7:0]  = s.led_fn;
      OFS_ISTS:   r[IRQ_W-1:0] = s.ists;
      OFS_IMSK:   r[IRQ_W-1:0] = s.imsk;
      OFS_LINE:   r[3:0]  = {s.din_s[1], s.pact, s.led, s.join_s[1]};
      default:    r = 33'h0;
    endcase
    return r;
  endfunction : iolc_rdval

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [32:0]      rdv;
    logic [31:0]      wm;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic             blink_en;
    logic [7:0]       eff;
    rdv      = 33'h0;
    wm       = 32'h0;
    ev       = '0;
    clr      = '0;
    blink_en = 1'b0;
    eff      = 8'h0;
    n        = q;

    // Pin synchronisers
    n.join_s = {q.join_s[0], joined_i};
    n.slp_s  = {q.slp_s[0], sleep_state_i};
    n.din_s  = {q.din_s[0], gpio_line_nine_i};

    // 10 ms and 100 ms enables
    n.t10  = 1'b0;
    n.t100 = 1'b0;
    if (q.div == TICK_CYC - 1) begin
      n.div = 32'h0;
      n.t10 = 1'b1;
      if (q.sub == 4'(PWM_DIV - 1)) begin
        n.sub  = 4'h0;
        n.t100 = 1'b1;
      end else begin
        n.sub = q.sub + 4'h1;
      end
    end else begin
      n.div = q.div + 32'h1;
    end

    // Register bus: write side
    if (s_axi_awvalid && q.awr) begin
      n.awg = 1'b1;
      n.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wr) begin
      n.wg = 1'b1;
      n.wd = s_axi_wdata;
      n.ws = s_axi_wstrb;
    end
    if (wr_do) begin
      rdv   = iolc_rdval(q, q.awa, supply_mv_i);
      wm    = iolc_merge(rdv[31:0], q.wd, q.ws);
      n.awg = 1'b0;
      n.wg  = 1'b0;
      n.bv  = 1'b1;
      n.br  = rdv[32] ? RESP_OKAY : RESP_SLVERR;
      unique case ({q.awa[7:2], 2'b00})
        OFS_SLP_FN: n.slp_fn = wm[7:0];
        OFS_LT:     n.lt     = wm[7:0];
        OFS_PR:     n.pr     = wm[14:0];
        OFS_PD:     n.pd     = wm[14:0];
        OFS_RP:     n.rp     = wm[7:0];
        OFS_THR:    n.thr    = wm[15:0];
        OFS_LED_FN: n.led_fn = wm[7:0];
        OFS_ISTS:   clr      = q.ws[0] ? q.wd[IRQ_W-1:0] : '0;
        OFS_IMSK:   n.imsk   = wm[IRQ_W-1:0];
        default:    n.br     = n.br;
      endcase
    end
    if (q.bv && s_axi_bready) begin
      n.bv = 1'b0;
    end
    n.awr = !n.awg && !n.bv;
    n.wr  = !n.wg && !n.bv;

    // Register bus: read side
    if (rd_do) begin
      rdv   = iolc_rdval(q, s_axi_araddr, supply_mv_i);
      n.arr = 1'b0;
      n.rv  = 1'b1;
      n.rd  = rdv[31:0];
      n.rr  = rdv[32] ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.rv && s_axi_rready) begin
      n.rv  = 1'b0;
      n.arr = 1'b1;
    end

    n.pu  = q.pr & q.pd;
    n.pdn = q.pr & ~q.pd;

    n.g9   = 1'b0;
    n.g9oe = 1'b1;
    unique case (q.slp_fn)
      FN_ALT:  n.g9 = q.slp_s[1];
      FN_LOW:  n.g9 = 1'b0;
      FN_HIGH: n.g9 = 1'b1;
      default: n.g9oe = 1'b0;
    endcase

    blink_en = (q.led_fn == FN_ALT) && q.join_s[1];
    eff      = (q.lt == 8'h00) ? BLINK_DEF : q.lt;
    if (!blink_en) begin
      n.bcnt = 8'h0;
      n.led  = 1'b0;
    end else if (q.t10) begin
      if (q.bcnt >= eff - 8'h01) begin
        n.bcnt = 8'h0;
        n.led  = !q.led;
      end else begin
        n.bcnt = q.bcnt + 8'h01;
      end
    end
    n.g5   = 1'b0;
    n.g5oe = 1'b1;
    unique case (q.led_fn)
      FN_ALT:  n.g5 = q.led;
      FN_LOW:  n.g5 = 1'b0;
      FN_HIGH: n.g5 = 1'b1;
      default: n.g5oe = 1'b0;
    endcase

    if (pkt_rx_i) begin
      ev[IRQ_PKT] = 1'b1;
      n.duty      = received_signal_strength_i;
      n.ptmr      = q.rp;
      n.pact      = (q.rp != 8'h00);
    end else if (q.pact && q.t100 && q.rp != RP_ALWAYS) begin
      if (q.ptmr <= 8'h01) begin
        n.pact          = 1'b0;
        ev[IRQ_PWM_END] = 1'b1;
      end
      if (q.ptmr != 8'h00) begin
        n.ptmr = q.ptmr - 8'h01;
      end
    end
    n.pcnt = q.pcnt + 8'h01;
    n.pwm  = q.pact && (q.pcnt < q.duty);

    n.smp   = smp_req_i;
    n.app   = 1'b0;
    n.amask = adc_mask_i;
    if (smp_req_i && q.thr != 16'h0 && supply_mv_i <= q.thr) begin
      n.app                 = 1'b1;
      n.amask[MASK_VIN_BIT] = 1'b1;
      ev[IRQ_LOW_VIN]       = 1'b1;
    end

    // Sticky status, set beats clear
    n.ists = (q.ists & ~clr) | ev;
    n.irq  = |(n.ists & n.imsk);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready       = q.awr;
  assign s_axi_wready        = q.wr;
  assign s_axi_bvalid        = q.bv;
  assign s_axi_bresp         = q.br;
  assign s_axi_arready       = q.arr;
  assign s_axi_rvalid        = q.rv;
  assign s_axi_rdata         = q.rd;
  assign s_axi_rresp         = q.rr;
  assign gpio_line_nine_o    = q.g9;
  assign gpio_line_nine_oe_o = q.g9oe;
  assign gpio_line_five_o    = q.g5;
  assign gpio_line_five_oe_o = q.g5oe;
  assign strength_pwm_o      = q.pwm;
  assign pull_en_o           = q.pr;
  assign pull_up_o           = q.pu;
  assign pull_dn_o           = q.pdn;
  assign smp_valid_o         = q.smp;
  assign smp_supply_o        = q.app;
  assign adc_mask_o          = q.amask;
  assign irq_o               = q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sleep_low_drive_a: assert property (
    q.slp_fn == FN_LOW |=> gpio_line_nine_oe_o && !gpio_line_nine_o)
    else $error("sleep line not driven low");
  led_step_tick_a: assert property (
    $changed(q.led) && $past(q.led_fn == FN_ALT && q.join_s[1])
      |-> $past(q.t10))
    else $error("LED toggled off a 10 ms step");
  pull_write_a: assert property (
    wr_do && {q.awa[7:2], 2'b00} == OFS_PR && q.ws == 4'hF
      |=> pull_en_o == $past(q.wd[14:0]))
    else $error("pull enable write lost");
  pull_dir_a: assert property (
    ##1 (pull_up_o | pull_dn_o) == $past(q.pr) && !(|(pull_up_o & pull_dn_o)))
    else $error("pull direction inconsistent");
  pwm_stop_a: assert property (
    $fell(q.pact) && !$past(pkt_rx_i)
      |-> $past(q.t100) && q.ists[IRQ_PWM_END])
    else $error("PWM stopped without timeout");
  pwm_always_a: assert property (
    q.pact && q.rp == RP_ALWAYS && !pkt_rx_i |=> q.pact)
    else $error("PWM timed out at 0xFF");
  supply_append_a: assert property (
    smp_req_i && q.thr != 16'h0 && supply_mv_i <= q.thr
      |=> smp_supply_o && adc_mask_o[MASK_VIN_BIT] && smp_valid_o)
    else $error("supply not appended");
  supply_off_a: assert property (
    smp_req_i && q.thr == 16'h0 |=> !smp_supply_o)
    else $error("supply appended with zero threshold");
  vin_read_a: assert property (
    rd_do && {s_axi_araddr[7:2], 2'b00} == OFS_VIN
      |=> s_axi_rdata == {16'h0, $past(supply_mv_i)})
    else $error("supply readback wrong");
  hw_read_a: assert property (
    rd_do && {s_axi_araddr[7:2], 2'b00} == OFS_HW
      |=> s_axi_rdata == {16'h0, HW_VERSION})
    else $error("hardware version readback wrong");
  fw_read_a: assert property (
    rd_do && {s_axi_araddr[7:2], 2'b00} == OFS_FW
      |=> s_axi_rdata == {16'h0, FW_VERSION} ##1 1'b1)
    else $error("firmware version readback wrong");
  pwm_restart_a: assert property (
    pkt_rx_i |=> q.ptmr == $past(q.rp) && q.duty == $past(
      received_signal_strength_i))
    else $error("packet did not restart PWM timer");

  pwm_timeout_c: cover property ($fell(q.pact));
  led_blink_c:   cover property ($rose(q.led) ##[1:1000] $fell(q.led));
  append_c:      cover property (smp_supply_o);
  write_resp_c:  cover property (s_axi_bvalid && s_axi_bready);

endmodule : iolc_top

// >>> dv/iolc_host_model.sv
// AXI4-Lite host model that reaches the block's registers
`timescale 1ns/1ps
module iolc_host_model (
  input  wire logic        ref_clk_i,
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  import iolc_pkg::*;
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
    wstrb_o = 4'hF;
  end
  // Address and data go out together; each drops once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_d;
    logic w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge ref_clk_i);
    awaddr_o <= a;
    awvalid_o <= 1'b1;
    wdata_o <= d;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge ref_clk_i);
      if (!aw_d && awready_i) begin
        aw_d = 1'b1;
        awvalid_o <= 1'b0;
      end
      if (!w_d && wready_i) begin
        w_d = 1'b1;
        wvalid_o <= 1'b0;
      end
    end
    do @(posedge ref_clk_i); while (!bvalid_i);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge ref_clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do @(posedge ref_clk_i); while (!arready_i);
    arvalid_o <= 1'b0;
    do @(posedge ref_clk_i); while (!rvalid_i);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask : rd
endmodule : iolc_host_model

// >>> dv/testbench.sv
// Self-checking bench for the I/O line, blink and PWM block
`timescale 1ns/1ps
module testbench;
  import iolc_pkg::*;
  localparam int unsigned TICK = 10;
  localparam logic [15:0] FW = 16'h0B07;  // Arbitrary value
  localparam logic [15:0] HW = 16'h3C02;  // Arbitrary value
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0]  r;
  } iolc_row_s;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, adc_mask_o;
  logic [7:0]  received_signal_strength_i = 8'h00;
  logic [7:0]  adc_mask_i = 8'h05;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, strength_pwm_o, irq_o, lv;
  logic        gpio_line_nine_o, gpio_line_nine_oe_o, gpio_line_five_o;
  logic        gpio_line_five_oe_o, smp_valid_o, smp_supply_o;
  logic        joined_i = 1'b1, sleep_state_i = 1'b1, pkt_rx_i = 1'b0;
  logic        gpio_line_nine_i = 1'b1, smp_req_i = 1'b0;
  logic [14:0] pull_en_o, pull_up_o, pull_dn_o;
  logic [15:0] supply_mv_i = 16'h0BB8;
  logic [7:0]  fc [6] = '{8'h0, 8'h1, 8'h4, 8'h5, 8'h2, 8'h3};
  logic [1:0]  fe [6] = '{2'h0, 2'h3, 2'h2, 2'h3, 2'h0, 2'h0};
  logic [15:0] thr [4] = '{16'h0, 16'h0BB8, 16'h0BB7, 16'hFFFF};
  logic        sup [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  int          error_cnt = 0, n_checks = 0, n, h;
  iolc_row_s   rows [18];

  always #5 ref_clk_i = ~ref_clk_i;

  iolc_top #(.TICK_CYC(TICK), .PWM_DIV(10), .FW_VERSION(FW),
             .HW_VERSION(HW)) dut (
    .ref_clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .joined_i, .sleep_state_i,
    .gpio_line_nine_i, .gpio_line_nine_o, .gpio_line_nine_oe_o,
    .gpio_line_five_o, .gpio_line_five_oe_o, .pkt_rx_i,
    .received_signal_strength_i, .strength_pwm_o, .pull_en_o,
    .pull_up_o, .pull_dn_o, .supply_mv_i, .smp_req_i, .adc_mask_i,
    .smp_valid_o, .smp_supply_o, .adc_mask_o, .irq_o);

  iolc_host_model host (
    .ref_clk_i, .awaddr_o(s_axi_awaddr), .awvalid_o(s_axi_awvalid),
    .awready_i(s_axi_awready), .wdata_o(s_axi_wdata),
    .wstrb_o(s_axi_wstrb), .wvalid_o(s_axi_wvalid),
    .wready_i(s_axi_wready), .bresp_i(s_axi_bresp),
    .bvalid_i(s_axi_bvalid), .bready_o(s_axi_bready),
    .araddr_o(s_axi_araddr), .arvalid_o(s_axi_arvalid),
    .arready_i(s_axi_arready), .rdata_i(s_axi_rdata),
    .rresp_i(s_axi_rresp), .rvalid_i(s_axi_rvalid),
    .rready_o(s_axi_rready));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask : cyc
  task automatic pkt(input logic [7:0] s);
    @(posedge ref_clk_i);
    pkt_rx_i <= 1'b1;
    received_signal_strength_i <= s;
    @(posedge ref_clk_i);
    pkt_rx_i <= 1'b0;
  endtask : pkt
  task automatic wait_irq(input int lim);
    while (irq_o !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_irq

  initial begin
    #400000;
    error_cnt++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rows = '{
      '{1'b0, OFS_SLP_FN, 32'h0, 32'h1, RESP_OKAY},
      '{1'b0, OFS_LT, 32'h0, 32'h0, RESP_OKAY},
      '{1'b0, OFS_PR, 32'h0, 32'h1FFF, RESP_OKAY},
      '{1'b0, OFS_PD, 32'h0, 32'h1FBF, RESP_OKAY},
      '{1'b0, OFS_RP, 32'h0, 32'h28, RESP_OKAY},
      '{1'b0, OFS_THR, 32'h0, 32'h0, RESP_OKAY},
      '{1'b0, OFS_FW, 32'h0, {16'h0, FW}, RESP_OKAY},
      '{1'b0, OFS_HW, 32'h0, {16'h0, HW}, RESP_OKAY},
      '{1'b0, OFS_LED_FN, 32'h0, 32'h1, RESP_OKAY},
      '{1'b0, OFS_IMSK, 32'h0, 32'h0, RESP_OKAY},
      '{1'b0, OFS_VIN, 32'h0, 32'h0BB8, RESP_OKAY},
      '{1'b0, 8'h40, 32'h0, 32'h0, RESP_SLVERR},
      '{1'b1, OFS_PR, 32'hFFFF, 32'h7FFF, RESP_OKAY},
      '{1'b1, OFS_PD, 32'h00FF, 32'h00FF, RESP_OKAY},
      '{1'b1, OFS_LT, 32'h0A, 32'h0A, RESP_OKAY},
      '{1'b1, OFS_THR, 32'h12345, 32'h2345, RESP_OKAY},
      '{1'b1, OFS_FW, 32'hFFFF, {16'h0, FW}, RESP_OKAY},
      '{1'b1, 8'h40, 32'h1, 32'h0, RESP_SLVERR}};
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        host.wr(rows[i].a, rows[i].d, r);
        chk(r, rows[i].r);
      end
      host.rd(rows[i].a, d, r);
      chk(d, rows[i].e);
      chk(r, rows[i].r);
    end
    cyc(1);
    chk(pull_en_o, 32'h7FFF);
    chk({1'b0, pull_up_o, 1'b0, pull_dn_o}, 32'h00FF_7F00);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    cyc(5);
    chk(pull_en_o, 32'h1FFF);
    chk({1'b0, pull_up_o, 1'b0, pull_dn_o}, 32'h1FBF_0040);
    chk({irq_o, s_axi_bvalid, strength_pwm_o}, 3'b000);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    cyc(2);
    foreach (fc[i]) begin
      host.wr(OFS_SLP_FN, {24'h0, fc[i]}, r);
      cyc(2);
      chk({gpio_line_nine_oe_o, gpio_line_nine_o & gpio_line_nine_oe_o},
          fe[i]);
    end
    host.rd(OFS_LINE, d, r);
    chk(d[3], 1'b1);
    host.wr(OFS_LT, 32'h0A, r);
    for (int k = 0; k < 2; k++) begin
      lv = gpio_line_five_o;
      n = 0;
      wait_led: while (gpio_line_five_o === lv && n < 400) begin
        cyc(1);
        n++;
      end
    end
    chk(n, 10 * TICK);
    @(posedge ref_clk_i);
    joined_i <= 1'b0;
    cyc(5);
    chk({gpio_line_five_oe_o, gpio_line_five_o}, 2'b10);
    host.wr(OFS_IMSK, 32'h4, r);
    foreach (thr[i]) begin
      host.wr(OFS_THR, {16'h0, thr[i]}, r);
      @(posedge ref_clk_i);
      smp_req_i <= 1'b1;
      @(posedge ref_clk_i);
      smp_req_i <= 1'b0;
      #1;
      chk({smp_valid_o, smp_supply_o, adc_mask_o},
          {1'b1, sup[i], sup[i], 7'h05});
      cyc(2);
      chk(irq_o, sup[i]);
      host.wr(OFS_ISTS, 32'h4, r);
      cyc(2);
      chk(irq_o, 1'b0);
    end
    host.wr(OFS_IMSK, 32'h2, r);
    host.wr(OFS_RP, 32'h5, r);
    pkt(8'h80);
    h = 0;
    cyc(2);
    repeat (256) begin
      cyc(1);
      if (strength_pwm_o === 1'b1) h++;
    end
    chk(h, 128);
    n = 258;
    wait_irq(1000);
    chk(n >= 400 && n <= 502, 1'b1);
    host.wr(OFS_ISTS, 32'h7, r);
    host.wr(OFS_RP, 32'h2, r);
    h = 0;
    repeat (6) begin
      pkt(8'h40);
      repeat (90) begin
        cyc(1);
        if (irq_o !== 1'b0) h++;
      end
    end
    chk(h, 0);
    n = 90;
    wait_irq(400);
    chk(n >= 100 && n <= 202, 1'b1);
    host.wr(OFS_ISTS, 32'h7, r);
    host.wr(OFS_RP, 32'hFF, r);
    pkt(8'h40);
    cyc(26000);
    host.rd(OFS_ISTS, d, r);
    chk(d[1], 1'b0);
    host.rd(OFS_LINE, d, r);
    chk(d[2], 1'b1);
    report_and_stop();
  end
endmodule : testbench
